// ===== pkg/fsro_pkg.sv
package fsro_pkg;

   // Command opcodes
   localparam logic [7:0] OP_WRITE_REGS = 8'h01;
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   localparam logic [7:0] OP_SET_LATCH = 8'h06;
   localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
   localparam logic [7:0] OP_CLEAR_STATUS = 8'h30;

   // Status byte layout
   localparam int POS_HPE = 7;
   localparam int POS_PERR = 6;
   localparam int POS_EERR = 5;
   localparam int POS_BP_HI = 4;
   localparam int POS_BP_LO = 2;
   localparam int POS_WEL = 1;
   localparam int POS_BUSY = 0;
   localparam int BP_W = 3;
   localparam int NV_W = 4;

   // Reset and reference values
   localparam logic [2:0] BP_NONE = 3'h0;
   localparam logic [2:0] BP_VOL_RESET = 3'h7;
   localparam logic [7:0] STAT_RESET = 8'h00;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] BYTE_OPCODE = 2'h0;
   localparam logic [1:0] BYTE_FIRST_DATA = 2'h1;
   localparam logic [1:0] BYTE_LATER = 2'h2;

   // Array operation kinds
   typedef enum logic [1:0] {
      FSRO_KIND_PROGRAM = 2'h0,
      FSRO_KIND_OTP = 2'h1,
      FSRO_KIND_SECTOR_ERASE = 2'h2,
      FSRO_KIND_BULK_ERASE = 2'h3
   } fsro_kind_t;

   // Operation state, Gray along idle-array-write-fault
   typedef enum logic [1:0] {
      FSRO_ST_IDLE = 2'h0,
      FSRO_ST_ARRAY = 2'h1,
      FSRO_ST_NVWR = 2'h3,
      FSRO_ST_FAULT = 2'h2
   } fsro_state_t;

endpackage

// ===== rtl/fsro_status.sv
`timescale 1ns/100ps
module fsro_status (
   // System clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Serial link pins
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe_n,
   // Protection pins and configuration
   input wire logic wp_n,
   input wire logic protect_volatility_select,
   input wire logic sw_reset_req,
   // Array engine request and answer
   input wire logic arr_req,
   input wire logic [1:0] arr_kind,
   input wire logic arr_target_protected,
   output logic arr_go,
   input wire logic arr_done,
   input wire logic arr_fail,
   input wire logic arr_hit_protected,
   // Suspend request
   input wire logic susp_req,
   input wire logic susp_erase,
   output logic susp_go,
   // Non-volatile store
   input wire logic [3:0] nv_stored,
   output logic nv_wr_req,
   output logic [3:0] nv_wr_data,
   input wire logic nv_done,
   // Status view
   output logic [7:0] status_reg_one,
   output logic hw_protect_enable,
   output logic [2:0] block_protect_bits
);

   ////////////////////////////////////////////////////////////////////////
   // Link side, clocked by the serial clock

   logic frame_rst, rd_active, cmd_tgl, stat_tgl, stat_ack, stat_tgl_meta, stat_tgl_sync;
   logic byte_end, op_end, data_end, relay_op, relay_wrr;
   logic [2:0] bit_idx;
   logic [1:0] byte_cnt;
   logic [7:0] shift_in, frame_op, rd_shift, cmd_op, cmd_data, stat_sck, stat_hold, next_byte;

   // Frame ends when select rises
   assign frame_rst = spi_cs_n | ~rst_n;
   assign next_byte = {shift_in[6:0], spi_mosi};
   assign byte_end = (bit_idx == fsro_pkg::BIT_LAST);
   assign op_end = byte_end & (byte_cnt == fsro_pkg::BYTE_OPCODE);
   assign data_end = byte_end & (byte_cnt == fsro_pkg::BYTE_FIRST_DATA);
   assign relay_op = op_end & (next_byte != fsro_pkg::OP_WRITE_REGS)
                     & (next_byte != fsro_pkg::OP_READ_STATUS);
   assign relay_wrr = data_end & (frame_op == fsro_pkg::OP_WRITE_REGS);

   // Bit and byte counting within a frame
   always_ff @(posedge spi_sck or posedge frame_rst) begin
      if (frame_rst) begin
         bit_idx <= 3'h0;
         byte_cnt <= 2'h0;
         shift_in <= 8'h00;
      end else begin
         bit_idx <= bit_idx + 3'h1;
         shift_in <= next_byte;
         if (byte_end && byte_cnt != fsro_pkg::BYTE_LATER) begin
            byte_cnt <= byte_cnt + 2'h1;
         end
      end
   end

   // Opcode capture and status shift for read
   always_ff @(posedge spi_sck or posedge frame_rst) begin
      if (frame_rst) begin
         frame_op <= 8'h00;
         rd_active <= 1'b0;
         rd_shift <= 8'h00;
      end else if (op_end) begin
         frame_op <= next_byte;
         rd_active <= (next_byte == fsro_pkg::OP_READ_STATUS);
         rd_shift <= stat_sck;
      end else if (rd_active && byte_end) begin
         rd_shift <= stat_sck;
      end else begin
         rd_shift <= {rd_shift[6:0], rd_shift[7]};
      end
   end

   // Command relay, opcode and data held until next toggle
   always_ff @(posedge spi_sck or negedge rst_n) begin
      if (!rst_n) begin
         cmd_op <= 8'h00;
         cmd_data <= 8'h00;
         cmd_tgl <= 1'b0;
      end else if (relay_op) begin
         cmd_op <= next_byte;
         cmd_tgl <= ~cmd_tgl;
      end else if (relay_wrr) begin
         cmd_op <= fsro_pkg::OP_WRITE_REGS;
         cmd_data <= next_byte;
         cmd_tgl <= ~cmd_tgl;
      end
   end

   // Status mirror handshake, receiving end
   always_ff @(posedge spi_sck or negedge rst_n) begin
      if (!rst_n) begin
         stat_tgl_meta <= 1'b0;
         stat_tgl_sync <= 1'b0;
         stat_ack <= 1'b0;
         stat_sck <= fsro_pkg::STAT_RESET;
      end else begin
         stat_tgl_meta <= stat_tgl;
         stat_tgl_sync <= stat_tgl_meta;
         if (stat_tgl_sync != stat_ack) begin
            stat_sck <= stat_hold;
            stat_ack <= stat_tgl_sync;
         end
      end
   end

   // Output data changes on the falling edge
   always_ff @(negedge spi_sck or posedge frame_rst) begin
      if (frame_rst) begin
         spi_miso <= 1'b0;
         spi_miso_oe_n <= 1'b1;
      end else begin
         spi_miso <= rd_shift[7];
         spi_miso_oe_n <= ~rd_active;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // System side synchronisers

   logic cmd_meta, cmd_sync, cmd_prev, wp_meta, wp_sync, ack_meta, ack_sync;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_meta <= 1'b0;
         cmd_sync <= 1'b0;
         cmd_prev <= 1'b0;
         wp_meta <= 1'b0;
         wp_sync <= 1'b0;
         ack_meta <= 1'b0;
         ack_sync <= 1'b0;
      end else begin
         cmd_meta <= cmd_tgl;
         cmd_sync <= cmd_meta;
         cmd_prev <= cmd_sync;
         wp_meta <= wp_n;
         wp_sync <= wp_meta;
         ack_meta <= stat_ack;
         ack_sync <= ack_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command and request decode

   fsro_pkg::fsro_state_t state, next_state;
   logic p_err, e_err, write_permit_latch, hpe, nv_loaded, run_erase, run_bulk;
   logic [2:0] bp_nv, bp_vol, bp_live;
   logic cmd_event, cmd_wrr, cmd_set, cmd_clr, cmd_clear_status_cmd;
   logic idle, may_write, hw_locked, wrr_ok;
   logic req_bulk, req_erase, bulk_refused, area_prot, arr_take, arr_start, prot_fault;
   logic arr_end, arr_ok, arr_bad, nv_end, set_perr, set_eerr;

   assign cmd_event = cmd_sync ^ cmd_prev;
   assign cmd_wrr = cmd_event & (cmd_op == fsro_pkg::OP_WRITE_REGS);
   assign cmd_set = cmd_event & (cmd_op == fsro_pkg::OP_SET_LATCH);
   assign cmd_clr = cmd_event & (cmd_op == fsro_pkg::OP_CLEAR_LATCH);
   assign cmd_clear_status_cmd = cmd_event & (cmd_op == fsro_pkg::OP_CLEAR_STATUS);

   // Selected block-protect copy
   assign bp_live = protect_volatility_select ? bp_vol : bp_nv;

   // Acceptance of writes
   assign idle = (state == fsro_pkg::FSRO_ST_IDLE);
   assign may_write = write_permit_latch & idle;
   assign hw_locked = hpe & ~wp_sync;
   assign wrr_ok = cmd_wrr & may_write & ~hw_locked;

   // Array request screening
   assign req_bulk = (arr_kind == fsro_pkg::FSRO_KIND_BULK_ERASE);
   assign req_erase = (arr_kind == fsro_pkg::FSRO_KIND_SECTOR_ERASE) | req_bulk;
   assign bulk_refused = req_bulk & (bp_live != fsro_pkg::BP_NONE);
   assign area_prot = ~req_bulk & arr_target_protected;
   assign arr_take = arr_req & may_write;
   assign arr_start = arr_take & ~bulk_refused & ~area_prot;
   assign prot_fault = arr_take & area_prot;
   assign arr_go = arr_start;

   // Ending of running operations
   assign arr_end = (state == fsro_pkg::FSRO_ST_ARRAY) & arr_done;
   assign arr_ok = arr_end & ~arr_fail;
   assign arr_bad = arr_end & arr_fail;
   assign nv_end = (state == fsro_pkg::FSRO_ST_NVWR) & nv_done;

   // Error setting by operation kind
   assign set_perr = (prot_fault & ~req_erase) | (arr_bad & ~run_erase);
   assign set_eerr = (prot_fault & req_erase)
                     | (arr_bad & run_erase & ~(run_bulk & arr_hit_protected));

   // Suspend only matches the running kind
   assign susp_go = susp_req & (state == fsro_pkg::FSRO_ST_ARRAY)
                    & (susp_erase == run_erase);

   ////////////////////////////////////////////////////////////////////////
   // Operation state

   always_comb begin
      next_state = state;
      case (state)
         fsro_pkg::FSRO_ST_IDLE: begin
            if (prot_fault) begin
               next_state = fsro_pkg::FSRO_ST_FAULT;
            end else if (arr_start) begin
               next_state = fsro_pkg::FSRO_ST_ARRAY;
            end else if (wrr_ok) begin
               next_state = fsro_pkg::FSRO_ST_NVWR;
            end
         end
         fsro_pkg::FSRO_ST_ARRAY: begin
            if (set_perr || set_eerr) begin
               next_state = fsro_pkg::FSRO_ST_FAULT;
            end else if (arr_end) begin
               next_state = fsro_pkg::FSRO_ST_IDLE;
            end
         end
         fsro_pkg::FSRO_ST_NVWR: begin
            if (nv_done) begin
               next_state = fsro_pkg::FSRO_ST_IDLE;
            end
         end
         fsro_pkg::FSRO_ST_FAULT: begin
            if (cmd_clear_status_cmd) begin
               next_state = fsro_pkg::FSRO_ST_IDLE;
            end
         end
         default: begin
            next_state = fsro_pkg::FSRO_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= fsro_pkg::FSRO_ST_IDLE;
      end else if (sw_reset_req) begin
         state <= fsro_pkg::FSRO_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Kind of the running array operation
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         run_erase <= 1'b0;
         run_bulk <= 1'b0;
      end else if (arr_start) begin
         run_erase <= req_erase;
         run_bulk <= req_bulk;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Error flags, set wins over clear

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         p_err <= 1'b0;
         e_err <= 1'b0;
      end else if (sw_reset_req) begin
         p_err <= 1'b0;
         e_err <= 1'b0;
      end else begin
         p_err <= set_perr | (p_err & ~cmd_clear_status_cmd);
         e_err <= set_eerr | (e_err & ~cmd_clear_status_cmd);
      end
   end

   // Write-permit latch
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         write_permit_latch <= 1'b0;
      end else if (sw_reset_req) begin
         write_permit_latch <= 1'b0;
      end else if (cmd_set && idle) begin
         write_permit_latch <= 1'b1;
      end else if ((cmd_clr && idle) || arr_ok || nv_end) begin
         write_permit_latch <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Protect bits and non-volatile store

   // Stored values caught after reset release
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         nv_loaded <= 1'b0;
         hpe <= 1'b0;
         bp_nv <= fsro_pkg::BP_NONE;
      end else if (!nv_loaded) begin
         nv_loaded <= 1'b1;
         hpe <= nv_stored[fsro_pkg::NV_W-1];
         bp_nv <= nv_stored[fsro_pkg::BP_W-1:0];
      end else if (wrr_ok) begin
         hpe <= cmd_data[fsro_pkg::POS_HPE];
         if (!protect_volatility_select) begin
            bp_nv <= cmd_data[fsro_pkg::POS_BP_HI:fsro_pkg::POS_BP_LO];
         end
      end
   end

   // Volatile copy returns to all-protected on reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bp_vol <= fsro_pkg::BP_VOL_RESET;
      end else if (sw_reset_req) begin
         bp_vol <= fsro_pkg::BP_VOL_RESET;
      end else if (wrr_ok && protect_volatility_select) begin
         bp_vol <= cmd_data[fsro_pkg::POS_BP_HI:fsro_pkg::POS_BP_LO];
      end
   end

   // Store write request for accepted register writes
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         nv_wr_req <= 1'b0;
         nv_wr_data <= 4'h0;
      end else begin
         nv_wr_req <= wrr_ok;
         if (wrr_ok) begin
            nv_wr_data <= {cmd_data[fsro_pkg::POS_HPE],
                           cmd_data[fsro_pkg::POS_BP_HI:fsro_pkg::POS_BP_LO]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status byte and its mirror toward the link

   assign status_reg_one = {hpe, p_err, e_err, bp_live, write_permit_latch, ~idle};
   assign hw_protect_enable = hpe;
   assign block_protect_bits = bp_live;

   // Publish a new snapshot once the last one was taken
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_hold <= fsro_pkg::STAT_RESET;
         stat_tgl <= 1'b0;
      end else if (ack_sync == stat_tgl && stat_hold != status_reg_one) begin
         stat_hold <= status_reg_one;
         stat_tgl <= ~stat_tgl;
      end
   end

endmodule

// ===== tb/fsro_host.sv
`timescale 1ns/100ps
// Host on the link: mode 0, clock runs only inside frames
module fsro_host (
   // Link pins
   output logic spi_sck,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire logic spi_miso
);
   initial begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One frame of n bits, MSB first; rx keeps the last eight bits read
   task automatic xfer(input logic [23:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      spi_cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         spi_mosi = tx[23-i];
         #80 spi_sck = 1'b1;
         rx = {rx[6:0], spi_miso};
         #80 spi_sck = 1'b0;
      end
      #80 spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi; // Released line shows no stale level
      #160;
   endtask
endmodule

// ===== tb/fsro_status_sva.sv
`timescale 1ns/100ps
module fsro_status_sva (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic sw_reset_req,
   // Link
   input wire logic spi_cs_n,
   input wire logic spi_miso_oe_n,
   // Array and suspend
   input wire logic arr_req,
   input wire logic [1:0] arr_kind,
   input wire logic arr_target_protected,
   input wire logic arr_go,
   input wire logic arr_done,
   input wire logic arr_fail,
   input wire logic arr_hit_protected,
   input wire logic susp_req,
   input wire logic susp_go,
   // Store and status
   input wire logic nv_wr_req,
   input wire logic [3:0] nv_wr_data,
   input wire logic nv_done,
   input wire logic [7:0] status_reg_one,
   input wire logic hw_protect_enable,
   input wire logic [2:0] block_protect_bits
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////////////
   // Array request gating, faults and operation end
   AST_GO_PROT: assert property (arr_go && arr_kind != 2'h3 |-> !arr_target_protected)
      else $error("start granted on protected target");
   AST_BULK_BP: assert property (arr_go && arr_kind == 2'h3 |-> block_protect_bits == 3'h0)
      else $error("bulk erase started with protect bits set");
   AST_GO_WEL: assert property (arr_go |-> status_reg_one[1] && !status_reg_one[0])
      else $error("start without latch or while busy");
   AST_GO_BUSY: assert property (arr_go |=> status_reg_one[0])
      else $error("busy not set after start");
   AST_FAULT: assert property (arr_req && arr_target_protected && arr_kind[1] == 1'b0
      && status_reg_one[1:0] == 2'h2 |=> status_reg_one[6] && status_reg_one[0])
      else $error("program error not raised");
   AST_ERR_BUSY: assert property (status_reg_one[6:5] != 2'h0 |-> status_reg_one[0])
      else $error("error flag without busy");
   AST_DONE_OK: assert property (arr_done && !arr_fail && status_reg_one[0]
      && status_reg_one[6:5] == 2'h0 |=> status_reg_one[1:0] == 2'h0)
      else $error("latch or busy kept after good end");
   AST_HIT_BULK: assert property (arr_done && arr_fail && arr_hit_protected
      && status_reg_one[6:5] == 2'h0 |=> !status_reg_one[5])
      else $error("erase error on bulk hit");
   // Store, register write, suspend, link output and resets
   AST_STORE_DATA: assert property (nv_wr_req |->
      nv_wr_data == {hw_protect_enable, block_protect_bits} && status_reg_one[0])
      else $error("store data or busy wrong");
   AST_WRR_ERR: assert property (nv_wr_req |-> $stable(status_reg_one[6:5]))
      else $error("error flags moved on register write");
   AST_STORE_DONE: assert property (nv_done |=> status_reg_one[1:0] == 2'h0)
      else $error("latch or busy kept after store");
   AST_SUSP: assert property (susp_go |-> susp_req && status_reg_one[0])
      else $error("suspend granted while idle");
   AST_OE_IDLE: assert property (spi_cs_n |-> spi_miso_oe_n)
      else $error("output driven outside frame");
   AST_RST: assert property ($rose(rst_n) |->
      status_reg_one[6:5] == 2'h0 && status_reg_one[1:0] == 2'h0)
      else $error("volatile bits not cleared by reset");
   AST_SWRST: assert property (sw_reset_req |=>
      status_reg_one[6:5] == 2'h0 && status_reg_one[1:0] == 2'h0)
      else $error("volatile bits not cleared by software reset");

   // Main scenarios
   cover property (arr_go);
   cover property (nv_wr_req);
   cover property (susp_go);
   cover property (status_reg_one[6]);
endmodule

bind fsro_status fsro_status_sva u_sva (.sys_clk, .rst_n, .sw_reset_req, .spi_cs_n,
   .spi_miso_oe_n, .arr_req,
   .arr_kind, .arr_target_protected, .arr_go, .arr_done, .arr_fail, .arr_hit_protected,
   .susp_req, .susp_go, .nv_wr_req, .nv_wr_data, .nv_done, .status_reg_one,
   .hw_protect_enable, .block_protect_bits);

// ===== tb/test_flash_status_register_one.sv
`timescale 1ns/100ps
module test_flash_status_register_one;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic wp_n = 1'b1;
   logic arr_req = 1'b0;
   logic [1:0] arr_kind = 2'h0;
   logic arr_target_protected = 1'b0;
   logic arr_done = 1'b0;
   logic arr_fail = 1'b0;
   logic arr_hit_protected = 1'b0;
   logic susp_req = 1'b0;
   logic susp_erase = 1'b0;
   logic nv_done = 1'b0;
   logic protect_volatility_select = 1'b0;
   logic sw_reset_req = 1'b0;
   logic spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n, arr_go, susp_go, nv_wr_req;
   logic hw_protect_enable;
   logic [2:0] block_protect_bits;
   logic [3:0] nv_wr_data;
   logic [3:0] nv_seen = 4'h0;
   logic [7:0] status_reg_one, rx;
   int fails = 0;
   int n_compared = 0;

   always #4 sys_clk = ~sys_clk;

   fsro_host host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso));

   fsro_status dut (.sys_clk(sys_clk), .rst_n(rst_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n), .wp_n(wp_n),
      .protect_volatility_select(protect_volatility_select), .sw_reset_req(sw_reset_req),
      .arr_req(arr_req),
      .arr_kind(arr_kind), .arr_target_protected(arr_target_protected), .arr_go(arr_go),
      .arr_done(arr_done), .arr_fail(arr_fail), .arr_hit_protected(arr_hit_protected),
      .susp_req(susp_req), .susp_erase(susp_erase), .susp_go(susp_go), .nv_stored(nv_seen),
      .nv_wr_req(nv_wr_req), .nv_wr_data(nv_wr_data), .nv_done(nv_done),
      .status_reg_one(status_reg_one), .hw_protect_enable(hw_protect_enable),
      .block_protect_bits(block_protect_bits));

   // Store answers one cycle after each write request
   always @(posedge sys_clk) begin
      nv_done <= #1 nv_wr_req;
      if (nv_wr_req === 1'b1) nv_seen <= nv_wr_data;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Compare, frames and array requests
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmd(input logic [7:0] op, input logic [7:0] exp);
      host.xfer({op, 16'h0000}, 8, rx);
      chk(status_reg_one, exp);
   endtask

   task automatic write_registers_cmd(input logic [7:0] d, input logic [7:0] exp);
      host.xfer({8'h01, d, 8'h00}, 16, rx);
      chk(status_reg_one, exp);
   endtask

   task automatic rd(input logic [7:0] exp);
      host.xfer({8'h05, 16'h0000}, 24, rx);
      chk(rx, exp);
   endtask

   task automatic arr(input logic [1:0] k, input logic p, f, h, go, input logic [7:0] exp);
      @(posedge sys_clk);
      #1 arr_kind = k;
      arr_target_protected = p;
      arr_req = 1'b1;
      #6 chk({7'h00, arr_go}, {7'h00, go});
      @(posedge sys_clk);
      #1 arr_req = 1'b0;
      if (go) begin
         susp_req = 1'b1;
         susp_erase = k[1];
         #6 chk({7'h00, susp_go}, 8'h01);
         @(posedge sys_clk);
         #1 susp_erase = ~k[1];
         #6 chk({7'h00, susp_go}, 8'h00);
         @(posedge sys_clk);
         #1 susp_req = 1'b0;
         arr_done = 1'b1;
         arr_fail = f;
         arr_hit_protected = h;
         @(posedge sys_clk);
         #1 arr_done = 1'b0;
         arr_fail = 1'b0;
         arr_hit_protected = 1'b0;
      end
      repeat (3) @(posedge sys_clk);
      #1 chk(status_reg_one, exp);
   endtask

   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Hang guard
   initial begin
      repeat (100000) @(posedge sys_clk);
      fails++;
      finish_test;
   end

   // Main sequence
   initial begin
      repeat (6) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge sys_clk);
      #1 chk(status_reg_one, 8'h00);
      rd(8'h00);
      write_registers_cmd(8'h9c, 8'h00);
      cmd(8'h06, 8'h02);
      cmd(8'h04, 8'h00);
      cmd(8'h06, 8'h02);
      write_registers_cmd(8'hfc, 8'h9c);
      chk({4'h0, nv_seen}, 8'h0f);
      rd(8'h9c);
      cmd(8'h06, 8'h9e);
      // Mid-run reset: latch drops, stored protect bits come back
      @(posedge sys_clk);
      #1 rst_n = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 chk(status_reg_one, 8'h9c);
      chk({hw_protect_enable, 4'h0, block_protect_bits}, 8'h87);
      cmd(8'h06, 8'h9e);
      arr(2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 8'h9e);
      wp_n = 1'b0;
      write_registers_cmd(8'h00, 8'h9e);
      wp_n = 1'b1;
      write_registers_cmd(8'h00, 8'h00);
      cmd(8'h06, 8'h02);
      arr(2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
      cmd(8'h06, 8'h02);
      arr(2'h1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h43);
      cmd(8'h04, 8'h43);
      rd(8'h43);
      cmd(8'h30, 8'h02);
      cmd(8'h04, 8'h00);
      cmd(8'h06, 8'h02);
      arr(2'h2, 1'b0, 1'b1, 1'b0, 1'b1, 8'h23);
      cmd(8'h30, 8'h02);
      cmd(8'h04, 8'h00);
      cmd(8'h06, 8'h02);
      arr(2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 8'h23);
      cmd(8'h30, 8'h02);
      arr(2'h3, 1'b0, 1'b1, 1'b1, 1'b1, 8'h02);
      cmd(8'h04, 8'h00);
      // Volatile protect copy, then software reset out of a fault
      protect_volatility_select = 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 chk(status_reg_one, 8'h1c);
      cmd(8'h06, 8'h1e);
      write_registers_cmd(8'h08, 8'h08);
      protect_volatility_select = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 chk(status_reg_one, 8'h00);
      protect_volatility_select = 1'b1;
      cmd(8'h06, 8'h0a);
      arr(2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h4b);
      sw_reset_req = 1'b1;
      @(posedge sys_clk);
      #1 sw_reset_req = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 chk(status_reg_one, 8'h1c);
      finish_test;
   end
endmodule
